/* File: hdl/lct_line_cfg_regs.sv */
// Overview of operation
// - Bit 7 picks type 1 or 2/3 thresholds.
// - Bit 6 picks current source or sink.
// - Bits 5:4 pick off/5mA/2mA/150uA.
// - Bit 3 NPN/PNP, ignored in push-pull.
// - Bit 2 picks push-pull or open-drain.
// - Bit 1 disables driver, line floats.
// - Bit 0 enables 1.3us receiver glitch filter.
// - Period register: base 7:6, multiplier 5:0.
// - Base 00: multiplier times 0.1ms.
// - Base 01: 6.4ms plus multiplier times 0.4ms.
// - Base 10: 32ms plus multiplier times 1.6ms.
// - Channel B has its own period register.
`timescale 1ns/10ps
`include "lct_consts.svh"

module lct_line_cfg_regs #(
   parameter int TICK_CYCLES = `LCT_TICK_CYCLES,
   parameter int FILTER_CYCLES = `LCT_FILTER_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic spi_sclk_i,
   input wire logic spi_csn_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_o,
   input wire logic period_timer_on_a_i,
   input wire logic period_timer_on_b_i,
   output logic [1:0] cycle_start_o,
   input wire logic tx_data_b_i,
   input wire logic line_pin_b_i,
   output logic line_pin_b_o,
   output logic line_pin_b_oe_o,
   output logic rx_data_b_o,
   output lct_pkg::lct_line_cfg_s line_cfg_b_o
);

   // Period of one register setting in 0.1 ms ticks; zero means no period
   function automatic logic [10:0] lct_period_ticks(input lct_pkg::lct_period_s p);
      logic [10:0] m;
      m = {5'h00, p.mult};
      unique case (p.base)
         2'b00: lct_period_ticks = m;
         2'b01: lct_period_ticks = `LCT_BASE01_OFFSET + (m << `LCT_BASE01_SHIFT);
         2'b10: lct_period_ticks = `LCT_BASE10_OFFSET + (m << `LCT_BASE10_SHIFT);
         default: lct_period_ticks = 11'h000;
      endcase
   endfunction : lct_period_ticks

   // Synchroniser stages for the serial pins
   logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
   logic csn_s1_q, csn_s2_q;
   logic mosi_s1_q, mosi_s2_q;
   // Synchroniser stages for the line receiver
   logic rx_s1_q, rx_s2_q;
   // Frame state
   lct_pkg::lct_spi_state_e spi_state_q;
   logic [3:0] bit_cnt_q;
   logic [6:0] shift_in_q;
   logic [7:0] cmd_q;
   logic [7:0] rd_shift_q;
   // Register contents
   lct_pkg::lct_period_s period_q [2];
   // Glitch filter counter
   logic [7:0] filt_cnt_q;
   // Tick divider
   logic [15:0] tick_cnt_q;
   logic tick_q;
   // Decoded strobes
   logic sclk_rise, sclk_fall, wr_fire, rd_fire;
   logic [7:0] wr_data;
   logic [7:0] rd_data;

   // Edge detection uses only the second and third stages
   assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
   assign sclk_fall = ~sclk_s2_q & sclk_s3_q;
   assign wr_data = {shift_in_q, mosi_s2_q};
   assign wr_fire = sclk_rise & ~csn_s2_q & (spi_state_q == lct_pkg::LCT_SPI_DATA)
      & (bit_cnt_q == 4'hf) & ~cmd_q[`LCT_CMD_READ_BIT];
   assign rd_fire = sclk_rise & ~csn_s2_q & (spi_state_q == lct_pkg::LCT_SPI_CMD) & (bit_cnt_q == 4'h7);

   // Read mux; unmapped addresses read zero
   always_comb begin
      unique case (wr_data[6:0])
         `LCT_ADDR_LINE_CFG_B: rd_data = line_cfg_b_o;
         `LCT_ADDR_PERIOD_A: rd_data = period_q[0];
         `LCT_ADDR_PERIOD_B: rd_data = period_q[1];
         default: rd_data = 8'h00;
      endcase
   end

   // Two-stage synchronisers for the pin inputs; sclk has a third stage for edge detection
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
         sclk_s3_q <= 1'b0;
         csn_s1_q <= 1'b1;
         csn_s2_q <= 1'b1;
         mosi_s1_q <= 1'b0;
         mosi_s2_q <= 1'b0;
         rx_s1_q <= 1'b0;
         rx_s2_q <= 1'b0;
      end else begin
         sclk_s1_q <= spi_sclk_i;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
         csn_s1_q <= spi_csn_i;
         csn_s2_q <= csn_s1_q;
         mosi_s1_q <= spi_mosi_i;
         mosi_s2_q <= mosi_s1_q;
         rx_s1_q <= line_pin_b_i;
         rx_s2_q <= rx_s1_q;
      end
   end

   // Frame sequencer: command byte, then data byte
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         spi_state_q <= lct_pkg::LCT_SPI_CMD;
         bit_cnt_q <= 4'h0;
         shift_in_q <= 7'h00;
         cmd_q <= 8'h00;
      end else if (csn_s2_q) begin
         // Deselect restarts the frame
         spi_state_q <= lct_pkg::LCT_SPI_CMD;
         bit_cnt_q <= 4'h0;
      end else if (sclk_rise) begin
         shift_in_q <= wr_data[6:0];
         bit_cnt_q <= bit_cnt_q + 4'h1;
         unique case (spi_state_q)
            lct_pkg::LCT_SPI_CMD: begin
               if (bit_cnt_q == 4'h7) begin
                  cmd_q <= wr_data;
                  spi_state_q <= lct_pkg::LCT_SPI_DATA;
               end
            end
            lct_pkg::LCT_SPI_DATA: begin
               if (bit_cnt_q == 4'hf) begin
                  spi_state_q <= lct_pkg::LCT_SPI_DONE;
               end
            end
            lct_pkg::LCT_SPI_DONE: begin
               // Extra clocks are ignored until deselect
               bit_cnt_q <= bit_cnt_q;
            end
         endcase
      end
   end

   // Read data shifter, launched on falling clock edges
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_shift_q <= 8'h00;
         spi_miso_o <= 1'b0;
         spi_miso_oe_o <= 1'b0;
      end else if (csn_s2_q) begin
         spi_miso_oe_o <= 1'b0;
         spi_miso_o <= 1'b0;
      end else if (rd_fire) begin
         rd_shift_q <= rd_data;
         spi_miso_oe_o <= wr_data[`LCT_CMD_READ_BIT];
      end else if (sclk_fall && spi_state_q == lct_pkg::LCT_SPI_DATA) begin
         spi_miso_o <= rd_shift_q[7];
         rd_shift_q <= {rd_shift_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         line_cfg_b_o <= `LCT_RST_LINE_CFG_B;
         period_q[0] <= `LCT_RST_PERIOD;
         period_q[1] <= `LCT_RST_PERIOD;
      end else if (wr_fire) begin
         unique case (cmd_q[6:0])
            `LCT_ADDR_LINE_CFG_B: line_cfg_b_o <= wr_data;
            `LCT_ADDR_PERIOD_A: period_q[0] <= wr_data;
            `LCT_ADDR_PERIOD_B: period_q[1] <= wr_data;
            default: line_cfg_b_o <= line_cfg_b_o;
         endcase
      end
   end

   // Line driver; threshold, direction and level leave as line_cfg_b_o
   // threshold class output
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         line_pin_b_o <= 1'b0;
         line_pin_b_oe_o <= 1'b0;
      end else if (line_cfg_b_o.line_driver_off) begin
         line_pin_b_o <= 1'b0;
         line_pin_b_oe_o <= 1'b0;
      end else if (line_cfg_b_o.driver_topology_sel) begin
         line_pin_b_o <= tx_data_b_i;
         line_pin_b_oe_o <= 1'b1;
      end else if (line_cfg_b_o.open_drain_polarity) begin
         line_pin_b_o <= 1'b0;
         line_pin_b_oe_o <= ~tx_data_b_i;
      end else begin
         line_pin_b_o <= 1'b1;
         line_pin_b_oe_o <= tx_data_b_i;
      end
   end

   // Receiver glitch filter: level must hold for the filter time
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_data_b_o <= 1'b0;
         filt_cnt_q <= 8'h00;
      end else if (!line_cfg_b_o.burst_filter_on) begin
         rx_data_b_o <= rx_s2_q;
         filt_cnt_q <= 8'h00;
      end else if (rx_s2_q == rx_data_b_o) begin
         filt_cnt_q <= 8'h00;
      end else if (filt_cnt_q == 8'(FILTER_CYCLES - 1)) begin
         rx_data_b_o <= rx_s2_q;
         filt_cnt_q <= 8'h00;
      end else begin
         filt_cnt_q <= filt_cnt_q + 8'h01;
      end
   end

   // 0.1 ms tick divider
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tick_cnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == 16'(TICK_CYCLES - 1)) begin
         tick_cnt_q <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end

   // Per-channel cycle timers
   logic [1:0] timer_on;
   assign timer_on = {period_timer_on_b_i, period_timer_on_a_i};

   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_timer
         logic [10:0] cnt_q;
         logic [10:0] period;
         assign period = lct_period_ticks(period_q[ch]);

         always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               cnt_q <= 11'h000;
               cycle_start_o[ch] <= 1'b0;
            end else if (!timer_on[ch] || period == 11'h000) begin
               cnt_q <= 11'h000;
               cycle_start_o[ch] <= 1'b0;
            end else if (tick_q && cnt_q >= period - 11'h001) begin
               cnt_q <= 11'h000;
               cycle_start_o[ch] <= 1'b1;
            end else begin
               cnt_q <= cnt_q + {10'h000, tick_q};
               cycle_start_o[ch] <= 1'b0;
            end
         end
      end
   endgenerate

   // Helper: cycles since the last channel A pulse
   logic [23:0] gap_q;
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         gap_q <= 24'h00_0000;
      end else if (cycle_start_o[0] || !timer_on[0]) begin
         gap_q <= 24'h00_0000;
      end else begin
         gap_q <= gap_q + 24'h00_0001;
      end
   end

   // Helper: armed after one channel A pulse, so only whole periods are judged
   logic gap_arm_q;
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         gap_arm_q <= 1'b0;
      end else if (!timer_on[0] || (wr_fire && cmd_q[6:0] == `LCT_ADDR_PERIOD_A)) begin
         // Enable edge or new setting: the next gap may be partial
         gap_arm_q <= 1'b0;
      end else if (cycle_start_o[0]) begin
         gap_arm_q <= 1'b1;
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_write_cfg;
      wr_fire && cmd_q[6:0] == `LCT_ADDR_LINE_CFG_B;
   endsequence

   cfg_write_a: assert property (s_write_cfg |=> line_cfg_b_o == $past(wr_data))
      else $error("line config write not stored");
   read_keep_a: assert property (!wr_fire |=> $stable(line_cfg_b_o) && $stable(period_q[0]) && $stable(period_q[1]))
      else $error("register changed without write");
   drv_off_a: assert property (line_cfg_b_o.line_driver_off[*2] |-> !line_pin_b_oe_o)
      else $error("disabled driver still enabled");
   push_pull_a: assert property (line_cfg_b_o.driver_topology_sel && !line_cfg_b_o.line_driver_off
      |=> line_pin_b_oe_o && line_pin_b_o == $past(tx_data_b_i))
      else $error("push-pull output wrong");
   npn_low_a: assert property ($past(!line_cfg_b_o.driver_topology_sel && line_cfg_b_o.open_drain_polarity
      && !line_cfg_b_o.line_driver_off) && line_pin_b_oe_o |-> !line_pin_b_o)
      else $error("NPN driver drove high");
   filt_off_a: assert property (!line_cfg_b_o.burst_filter_on |=> rx_data_b_o == $past(rx_s2_q))
      else $error("unfiltered receiver lagging");
   filt_hold_a: assert property (line_cfg_b_o.burst_filter_on && $past(line_cfg_b_o.burst_filter_on)
      && $changed(rx_data_b_o) |-> filt_cnt_q == 8'h00 && $past(filt_cnt_q) == 8'(FILTER_CYCLES - 1))
      else $error("filter passed a short glitch");
   timer_off_a: assert property (!period_timer_on_a_i |=> !cycle_start_o[0])
      else $error("disabled timer fired");
   base_bad_a: assert property (period_q[1].base == 2'b11 |=> !cycle_start_o[1])
      else $error("undefined time base fired");
   period_gap_a: assert property (cycle_start_o[0] && gap_arm_q |-> gap_q + 24'h00_0001
      == 24'(lct_period_ticks(period_q[0])) * 24'(TICK_CYCLES))
      else $error("cycle period wrong");

endmodule : lct_line_cfg_regs

/* File: hdl/lct_consts.svh */
`ifndef LCT_CONSTS_SVH
`define LCT_CONSTS_SVH

// Register offsets on the serial port
`define LCT_ADDR_LINE_CFG_B 7'h11
`define LCT_ADDR_PERIOD_A 7'h12
`define LCT_ADDR_PERIOD_B 7'h13

// Reset values
`define LCT_RST_LINE_CFG_B 8'h00
`define LCT_RST_PERIOD 8'h00

// Line configuration field positions
`define LCT_BIT_THRESHOLD 7
`define LCT_BIT_DIRECTION 6
`define LCT_BIT_LEVEL_HI 5
`define LCT_BIT_LEVEL_LO 4
`define LCT_BIT_OD_POLARITY 3
`define LCT_BIT_TOPOLOGY 2
`define LCT_BIT_DRV_OFF 1
`define LCT_BIT_FILTER 0

// Period register field positions
`define LCT_BIT_BASE_HI 7
`define LCT_BIT_BASE_LO 6
`define LCT_BIT_MULT_HI 5
`define LCT_BIT_MULT_LO 0

// Period arithmetic, in 0.1 ms ticks
`define LCT_BASE01_OFFSET 11'h040
`define LCT_BASE10_OFFSET 11'h140
`define LCT_BASE01_SHIFT 2
`define LCT_BASE10_SHIFT 4

// Timing
`define LCT_CLK_PERIOD_NS 10
`define LCT_FILTER_TIME_NS 1300
`define LCT_FILTER_CYCLES ((`LCT_FILTER_TIME_NS + `LCT_CLK_PERIOD_NS - 1) / `LCT_CLK_PERIOD_NS)
`define LCT_TICK_TIME_NS 100000
`define LCT_TICK_CYCLES (`LCT_TICK_TIME_NS / `LCT_CLK_PERIOD_NS)

// Serial frame layout
`define LCT_FRAME_BITS 16
`define LCT_CMD_READ_BIT 7

`endif

/* File: hdl/lct_pkg.sv */
package lct_pkg;

   // Line configuration, laid out as the register bits 7..0
   typedef struct packed {
      logic threshold_class_sel;
      logic current_direction_sel;
      logic [1:0] current_level_sel;
      logic open_drain_polarity;
      logic driver_topology_sel;
      logic line_driver_off;
      logic burst_filter_on;
   } lct_line_cfg_s;

   // Cycle period register, time-base code over multiplier
   typedef struct packed {
      logic [1:0] base;
      logic [5:0] mult;
   } lct_period_s;

   // Serial port frame phases
   typedef enum logic [2:0] {
      LCT_SPI_CMD = 3'b001,
      LCT_SPI_DATA = 3'b010,
      LCT_SPI_DONE = 3'b100
   } lct_spi_state_e;

endpackage : lct_pkg

/* File: verif/lct_field_dev.sv */
`timescale 1ns/10ps

// Field sensor on the line pin: drives a level on request, otherwise its sink pulls the line low
module lct_field_dev (
   input wire logic sensor_drive_i,
   input wire logic sensor_level_i,
   input wire logic dut_out_i,
   input wire logic dut_oe_i,
   output logic line_o
);
   // Wire level from both parties; a released line settles at the sink level
   always_comb begin
      if (dut_oe_i) begin
         line_o = dut_out_i;
      end else if (sensor_drive_i) begin
         line_o = sensor_level_i;
      end else begin
         line_o = 1'b0;
      end
   end
endmodule : lct_field_dev

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
`include "lct_consts.svh"

module tb_top;
   localparam int TICK = 10;
   localparam int FILT = 8;
   logic clk = 1'b0;
   logic rstn, sclk, csn, mosi, miso, ton_a, ton_b, txd, line, lout, loe, rxd, s_drv, s_lvl;
   logic [1:0] cyc;
   logic moe, moe_seen;
   lct_pkg::lct_line_cfg_s cfg;
   int miscompares = 0;
   int num_checks = 0;
   int pulses_a = 0;

   // Core clock, 10 ns period
   initial begin
      forever #5 clk = ~clk;
   end

   // Counts channel A pulses for the gating check
   always @(posedge clk) begin
      if (cyc[0] === 1'b1) begin
         pulses_a++;
      end
   end

   lct_line_cfg_regs #(.TICK_CYCLES(TICK), .FILTER_CYCLES(FILT)) lct_line_cfg_regs_i (
      .core_clk_i(clk), .rstn_i(rstn), .spi_sclk_i(sclk), .spi_csn_i(csn), .spi_mosi_i(mosi),
      .spi_miso_o(miso), .spi_miso_oe_o(moe), .period_timer_on_a_i(ton_a), .period_timer_on_b_i(ton_b),
      .cycle_start_o(cyc), .tx_data_b_i(txd), .line_pin_b_i(line), .line_pin_b_o(lout),
      .line_pin_b_oe_o(loe), .rx_data_b_o(rxd), .line_cfg_b_o(cfg));

   lct_field_dev lct_field_dev_i (.sensor_drive_i(s_drv), .sensor_level_i(s_lvl), .dut_out_i(lout),
      .dut_oe_i(loe), .line_o(line));

   // Waits n edges, then steps off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // Compares and counts
   task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // Verdict and end of run
   task automatic stop_test();
      if (miscompares == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : stop_test

   // One 16-bit frame, MSB first; sclk phases of 6 core clocks keep clear of the input sync lag
   task automatic frame(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
      logic [15:0] sh;
      sh = {cmd, wd};
      rd = 8'h00;
      csn = 1'b0;
      tick(6);
      for (int i = 15; i >= 0; i--) begin
         mosi = sh[i];
         tick(6);
         sclk = 1'b1;
         if (i < 8) begin
            rd[i] = miso;
            moe_seen = moe;
         end
         tick(6);
         sclk = 1'b0;
      end
      tick(6);
      csn = 1'b1;
      tick(6);
   endtask : frame

   // Register write
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] x;
      frame({1'b0, a}, d, x);
   endtask : wr

   // Register read and compare
   task automatic rdchk(input string n, input logic [6:0] a, input logic [7:0] e);
      logic [7:0] x;
      frame({1'b1, a}, 8'h00, x);
      check(n, {8'h00, x}, {8'h00, e});
      check("miso_oe", {15'h0000, moe_seen}, 16'h0001);
      check("miso_oe_off", {15'h0000, moe}, 16'h0000);
   endtask : rdchk

   task automatic t_reset();
      check("cfg_rst", {8'h00, cfg}, {8'h00, `LCT_RST_LINE_CFG_B});
      rdchk("cfg_rst_rd", `LCT_ADDR_LINE_CFG_B, 8'h00);
      rdchk("pa_rst_rd", `LCT_ADDR_PERIOD_A, 8'h00);
      rdchk("pb_rst_rd", `LCT_ADDR_PERIOD_B, 8'h00);
   endtask : t_reset

   task automatic t_regs();
      wr(`LCT_ADDR_LINE_CFG_B, 8'ha5);
      check("cfg_a5", {8'h00, cfg}, 16'h00a5);
      wr(`LCT_ADDR_LINE_CFG_B, 8'h5a);
      check("cfg_5a", {8'h00, cfg}, 16'h005a);
      check("cfg_lvl", {14'h0000, cfg.current_level_sel}, 16'h0001);
      wr(`LCT_ADDR_PERIOD_A, 8'h85);
      wr(`LCT_ADDR_PERIOD_B, 8'h7e);
      wr(7'h14, 8'hff);
      rdchk("cfg_rd", `LCT_ADDR_LINE_CFG_B, 8'h5a);
      rdchk("pa_rd", `LCT_ADDR_PERIOD_A, 8'h85);
      rdchk("pb_rd", `LCT_ADDR_PERIOD_B, 8'h7e);
      rdchk("pb_reread", `LCT_ADDR_PERIOD_B, 8'h7e);
      rdchk("unmapped", 7'h14, 8'h00);
   endtask : t_regs

   // driver modes, with the line seen back on the receiver
   task automatic t_drive();
      logic [7:0] mode [5] = '{8'h04, 8'h0c, 8'h08, 8'h00, 8'h06};
      logic eoe, eout;
      for (int m = 0; m < 5; m++) begin
         wr(`LCT_ADDR_LINE_CFG_B, mode[m]);
         for (int t = 0; t < 2; t++) begin
            txd = t[0];
            tick(8);
            eoe = mode[m][1] ? 1'b0 : (mode[m][2] ? 1'b1 : (mode[m][3] ? ~t[0] : t[0]));
            eout = mode[m][2] ? t[0] : ~mode[m][3];
            check("drv_oe", {15'h0000, loe}, {15'h0000, eoe});
            if (eoe) begin
               check("drv_out", {15'h0000, lout}, {15'h0000, eout});
            end
            check("rx_level", {15'h0000, rxd}, {15'h0000, eoe & eout});
         end
      end
      txd = 1'b0;
   endtask : t_drive

   // short glitch hidden only with the filter on
   task automatic t_filter();
      logic seen;
      s_drv = 1'b1;
      for (int f = 0; f < 2; f++) begin
         wr(`LCT_ADDR_LINE_CFG_B, {7'h01, f[0]});
         s_lvl = 1'b0;
         tick(20);
         seen = 1'b0;
         for (int c = 0; c < 24; c++) begin
            s_lvl = (c < 3);
            tick(1);
            seen |= rxd;
         end
         check("glitch", {15'h0000, seen}, {15'h0000, ~f[0]});
         s_lvl = 1'b1;
         tick(FILT + 12);
         check("steady", {15'h0000, rxd}, 16'h0001);
      end
      s_drv = 1'b0;
   endtask : t_filter

   // Waits for a pulse on one channel, counting cycles
   task automatic wait_pulse(input int ch, output int n);
      n = 0;
      while (cyc[ch] !== 1'b1 && n <= 5000) begin
         n++;
         tick(1);
      end
      if (n > 5000) begin
         check("timeout", 16'h0001, 16'h0000);
         stop_test();
      end else begin
         tick(1);
      end
   endtask : wait_pulse

   task automatic period_chk(input int ch, input logic [7:0] val, input int ticks);
      int n;
      wr(ch[0] ? `LCT_ADDR_PERIOD_B : `LCT_ADDR_PERIOD_A, val);
      ton_a = (ch == 0);
      ton_b = (ch == 1);
      wait_pulse(ch, n);
      wait_pulse(ch, n);
      check("period", 16'(n + 1), 16'(ticks * TICK));
      ton_a = 1'b0;
      ton_b = 1'b0;
      tick(2);
   endtask : period_chk

   // codes kept in range; channels independent
   task automatic t_timer();
      int held;
      period_chk(0, 8'h05, 5);
      period_chk(0, 8'h41, 68);
      held = pulses_a;
      period_chk(1, 8'h82, 352);
      period_chk(1, 8'h3f, 63);
      check("a_gated", 16'(pulses_a), 16'(held));
      rdchk("pa_kept", `LCT_ADDR_PERIOD_A, 8'h41);
   endtask : t_timer

   // Main sequence, ending with a second reset and a repeat of the reset checks
   initial begin
      rstn = 1'b0;
      sclk = 1'b0;
      csn = 1'b1;
      mosi = 1'b0;
      ton_a = 1'b0;
      ton_b = 1'b0;
      txd = 1'b0;
      s_drv = 1'b0;
      s_lvl = 1'b0;
      tick(8);
      rstn = 1'b1;
      tick(4);
      t_reset();
      t_regs();
      t_drive();
      t_filter();
      t_timer();
      rstn = 1'b0;
      tick(2);
      rstn = 1'b1;
      tick(4);
      t_reset();
      stop_test();
   end
endmodule : tb_top
